/* File: rtl/ssh_pin_sync.sv */
// Two-stage synchroniser for every asynchronous pin of the interface
`timescale 1ns/1ps
`default_nettype none

module ssh_pin_sync
	import ssh_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [SYNC_W-1:0] pinIn,
	output logic [SYNC_W-1:0] pinSync
);

	// Each bit has its own pair; the first stage feeds only the second
	genvar i;
	for (i = 0; i < SYNC_W; i++) begin : g_bit
		logic meta_reg;
		logic sync_reg;
		always_ff @(posedge clock) begin
			if (!rst_n) begin
				meta_reg <= SYNC_RESET[i];
				sync_reg <= SYNC_RESET[i];
			end else begin
				meta_reg <= pinIn[i];
				sync_reg <= meta_reg;
			end
		end
		assign pinSync[i] = sync_reg;
	end

endmodule : ssh_pin_sync

`default_nettype wire

/* File: rtl/ssh_pkg.sv */
// Constants and types shared by the sensor serial host interface
package ssh_pkg;

	// ----------------------------------------------------------------
	// Addresses and commands
	// ----------------------------------------------------------------
	localparam logic [6:0] I2C_TARGET_ADDR = 7'h28;
	localparam logic [7:0] CMD_START_CONV = 8'h8C;
	localparam logic [7:0] PRESS_BASE = 8'h40;
	localparam logic [7:0] TEMP_BASE = 8'h44;
	localparam logic [7:0] DATA_LAST = 8'h47;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] ADDR_STEP = 8'h01;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [3:0] BIT_RESET = 4'h0;

	// ----------------------------------------------------------------
	// Timing figures and their cycle counts at the core clock
	// ----------------------------------------------------------------
	localparam int CLOCK_MHZ = 200;
	localparam int I2C_MAX_KHZ = 100;
	localparam int I2C_PERIOD_CYC = (CLOCK_MHZ * 1000) / I2C_MAX_KHZ;
	localparam int SPI_HALF_NS = 500;
	localparam int SPI_HALF_CYC = (SPI_HALF_NS * CLOCK_MHZ) / 1000;
	localparam int CS_GAP_NS = 500;
	localparam int CS_GAP_CYC = (CS_GAP_NS * CLOCK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// Synchronised pin vector layout and idle levels
	// ----------------------------------------------------------------
	localparam int SYNC_W = 6;
	localparam int PIN_SEL = 0;
	localparam int PIN_SCL = 1;
	localparam int PIN_SDA = 2;
	localparam int PIN_SCLK = 3;
	localparam int PIN_CS = 4;
	localparam int PIN_MOSI = 5;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h16;

	// I2C target sequencer states, one-hot
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_WRITE = 7'h04,
		I2C_ACK_OUT = 7'h08,
		I2C_LOAD = 7'h10,
		I2C_READ = 7'h20,
		I2C_ACK_IN = 7'h40
	} ssh_i2c_state_t;

endpackage : ssh_pkg

/* File: rtl/ssh_serial_host_if.sv */
// Serial host interface: I2C target and SPI mode-1 target over a byte register space
// How it works
// - I2C target works with SCL up to 100 kHz; host stays below.
// - Target holds SCL low while next read data is not ready.
// - I2C single reads, single writes, multi reads; address auto-increments per byte.
// - SDA falling with SCL high is start; rising with SCL high is stop.
// - SDA changes only while SCL is low, except start and stop.
// - Bus busy from start to stop; repeated start acts as start.
// - Each unit is eight bits MSB first plus one acknowledge bit.
// - First byte is 7-bit address then direction bit, 0 write, 1 read.
// - Target answers only address 0x28, bytes 0x50 and 0x51.
// - One interface at a time: select high gives I2C, low gives SPI.
// - SPI is mode 1, CPOL 0 and CPHA 1, MSB first.
// - SPI supports single and multi-byte reads and writes.
// - SPI shifts addressed register out, then next register per byte.
// - Command 0x8C starts read-triggered conversions after each data read.
// - Reading anything but pressure or temperature stops conversions.
// - Pressure at 0x40..0x43, temperature at 0x44..0x47, low byte first.
`timescale 1ns/1ps
`default_nettype none

module ssh_serial_host_if
	import ssh_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic interfaceSelectPin,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic spiSclk,
	input wire logic spiCsN,
	input wire logic spiMosi,
	output logic spiMiso,
	output logic spiMisoOe,
	input wire logic [31:0] pressureData,
	input wire logic [31:0] temperatureData,
	input wire logic dataReady,
	input wire logic [7:0] regRdData,
	output logic [7:0] regRdAddr,
	output logic regWrEn,
	output logic [7:0] regWrAddr,
	output logic [7:0] regWrData,
	output logic convRunning,
	output logic convStart
);

	// ----------------------------------------------------------------
	// Pin sampling and edge detection
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] pinRaw;
	logic [SYNC_W-1:0] pinSync;
	logic [SYNC_W-1:0] pinPrev_reg;
	logic [SYNC_W-1:0] pinPrev_next;
	logic i2cOn, spiOn, sclS, sdaS, csS, mosiS;
	logic sclRise, sclFall, startEv, stopEv, sclkRise, sclkFall, csRise;

	assign pinRaw = {spiMosi, spiCsN, spiSclk, sdaIn, sclIn, interfaceSelectPin};

	ssh_pin_sync u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pinIn(pinRaw),
		.pinSync(pinSync)
	);

	// One previous copy of the synchronised pins gives every edge
	always_comb begin
		pinPrev_next = pinSync;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pinPrev_reg <= SYNC_RESET;
		end else begin
			pinPrev_reg <= pinPrev_next;
		end
	end

	// Sampling at 200 MHz leaves thousands of samples per 100 kHz bit
	assign i2cOn = pinSync[PIN_SEL];
	assign spiOn = !pinSync[PIN_SEL];
	assign sclS = pinSync[PIN_SCL];
	assign sdaS = pinSync[PIN_SDA];
	assign csS = pinSync[PIN_CS];
	assign mosiS = pinSync[PIN_MOSI];
	assign sclRise = sclS && !pinPrev_reg[PIN_SCL];
	assign sclFall = !sclS && pinPrev_reg[PIN_SCL];
	assign startEv = sclS && pinPrev_reg[PIN_SCL] && pinPrev_reg[PIN_SDA] && !sdaS;
	assign stopEv = sclS && pinPrev_reg[PIN_SCL] && !pinPrev_reg[PIN_SDA] && sdaS;
	assign sclkRise = pinSync[PIN_SCLK] && !pinPrev_reg[PIN_SCLK];
	assign sclkFall = !pinSync[PIN_SCLK] && pinPrev_reg[PIN_SCLK];
	assign csRise = csS && !pinPrev_reg[PIN_CS];

	// ----------------------------------------------------------------
	// Byte register space view
	// ----------------------------------------------------------------
	function automatic logic isData(input logic [7:0] a);
		return (a >= PRESS_BASE) && (a <= DATA_LAST);
	endfunction : isData

	logic [7:0] addr_reg;
	logic [7:0] rdByte;

	// Measurement bytes come little-endian from the sample words
	always_comb begin
		rdByte = regRdData;
		if (isData(addr_reg)) begin
			if (addr_reg >= TEMP_BASE) begin
				rdByte = temperatureData[{addr_reg[1:0], 3'h0} +: 8];
			end else begin
				rdByte = pressureData[{addr_reg[1:0], 3'h0} +: 8];
			end
		end
	end

	// ----------------------------------------------------------------
	// I2C target sequencer
	// ----------------------------------------------------------------
	ssh_i2c_state_t i2cState_reg, i2cState_next;
	logic [3:0] bitCnt_reg, bitCnt_next;
	logic [7:0] shift_reg, shift_next;
	logic rw_reg, rw_next, first_reg, first_next, busy_reg, busy_next;
	logic sdaLow_reg, sdaLow_next, sclHold_reg, sclHold_next;
	logic i2cLoad, i2cSetAddr, i2cWr, i2cCmd, i2cEnd;
	logic evAny;

	assign evAny = startEv || stopEv;

	// Sample on SCL rise, drive on SCL fall so SDA never moves with SCL high
	always_comb begin
		i2cState_next = i2cState_reg;
		bitCnt_next = bitCnt_reg;
		shift_next = shift_reg;
		rw_next = rw_reg;
		first_next = first_reg;
		busy_next = busy_reg;
		sdaLow_next = sdaLow_reg;
		sclHold_next = sclHold_reg;
		i2cLoad = 1'b0;
		i2cSetAddr = 1'b0;
		i2cWr = 1'b0;
		i2cCmd = 1'b0;
		i2cEnd = busy_reg && (!i2cOn || evAny);
		if (!i2cOn) begin
			i2cState_next = I2C_IDLE;
			busy_next = 1'b0;
			sdaLow_next = 1'b0;
			sclHold_next = 1'b0;
		end else if (evAny) begin
			busy_next = startEv;
			i2cState_next = startEv ? I2C_ADDR : I2C_IDLE;
			bitCnt_next = BIT_RESET;
			sdaLow_next = 1'b0;
			sclHold_next = 1'b0;
		end else begin
			unique case (i2cState_reg)
				I2C_IDLE: begin
					sdaLow_next = 1'b0;
				end
				I2C_ADDR, I2C_WRITE: begin
					if (sclRise) begin
						shift_next = {shift_reg[6:0], sdaS};
						bitCnt_next = bitCnt_reg + BIT_STEP;
					end else if (sclFall && bitCnt_reg == BITS_PER_BYTE) begin
						bitCnt_next = BIT_RESET;
						if (i2cState_reg == I2C_ADDR) begin
							if (shift_reg[7:1] == I2C_TARGET_ADDR) begin
								i2cState_next = I2C_ACK_OUT;
								sdaLow_next = 1'b1;
								rw_next = shift_reg[0];
								first_next = 1'b1;
							end else begin
								i2cState_next = I2C_IDLE;
							end
						end else begin
							i2cState_next = I2C_ACK_OUT;
							sdaLow_next = 1'b1;
							if (first_reg) begin
								i2cSetAddr = 1'b1;
								i2cCmd = (shift_reg == CMD_START_CONV);
								first_next = 1'b0;
							end else begin
								i2cWr = 1'b1;
							end
						end
					end
				end
				I2C_ACK_OUT: begin
					if (sclFall) begin
						sdaLow_next = 1'b0;
						i2cState_next = rw_reg ? I2C_LOAD : I2C_WRITE;
					end
				end
				I2C_LOAD: begin
					if (dataReady) begin
						// Data settles first; SCL is let go one cycle later
						shift_next = rdByte;
						sdaLow_next = !rdByte[7];
						i2cLoad = 1'b1;
						bitCnt_next = BIT_RESET;
						i2cState_next = I2C_READ;
					end else begin
						sclHold_next = 1'b1;
					end
				end
				I2C_READ: begin
					sclHold_next = 1'b0;
					if (sclRise) begin
						bitCnt_next = bitCnt_reg + BIT_STEP;
					end else if (sclFall) begin
						if (bitCnt_reg == BITS_PER_BYTE) begin
							sdaLow_next = 1'b0;
							i2cState_next = I2C_ACK_IN;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							sdaLow_next = !shift_reg[6];
						end
					end
				end
				I2C_ACK_IN: begin
					if (sclRise && sdaS) begin
						i2cState_next = I2C_IDLE;
					end else if (sclFall) begin
						i2cState_next = I2C_LOAD;
					end
				end
				default: begin
					i2cState_next = I2C_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			i2cState_reg <= I2C_IDLE;
			bitCnt_reg <= BIT_RESET;
			shift_reg <= ADDR_RESET;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			busy_reg <= 1'b0;
			sdaLow_reg <= 1'b0;
			sclHold_reg <= 1'b0;
		end else begin
			i2cState_reg <= i2cState_next;
			bitCnt_reg <= bitCnt_next;
			shift_reg <= shift_next;
			rw_reg <= rw_next;
			first_reg <= first_next;
			busy_reg <= busy_next;
			sdaLow_reg <= sdaLow_next;
			sclHold_reg <= sclHold_next;
		end
	end

	// ----------------------------------------------------------------
	// SPI mode-1 target
	// ----------------------------------------------------------------
	logic [3:0] spiBit_reg, spiBit_next;
	logic [7:0] spiRx_reg, spiRx_next, spiTx_reg, spiTx_next;
	logic [7:0] spiTxAddr_reg, spiTxAddr_next;
	logic spiFirst_reg, spiFirst_next, spiPend_reg, spiPend_next;
	logic spiMiso_reg, spiMiso_next, spiOe_reg, spiOe_next;
	logic [7:0] spiRxByte;
	logic spiLoad, spiSetAddr, spiWr, spiCmd, spiEnd, spiRead;

	assign spiRxByte = {spiRx_reg[6:0], mosiS};

	// Prefetch the next byte a cycle after each byte except a 0x8C command byte; reads count when shifted
	always_comb begin
		spiBit_next = spiBit_reg;
		spiRx_next = spiRx_reg;
		spiTx_next = spiTx_reg;
		spiTxAddr_next = spiTxAddr_reg;
		spiFirst_next = spiFirst_reg;
		spiPend_next = 1'b0;
		spiMiso_next = spiMiso_reg;
		spiOe_next = spiOe_reg;
		spiLoad = 1'b0;
		spiSetAddr = 1'b0;
		spiWr = 1'b0;
		spiCmd = 1'b0;
		spiRead = 1'b0;
		spiEnd = spiOn && csRise;
		if (!spiOn || csS) begin
			spiBit_next = BIT_RESET;
			spiFirst_next = 1'b1;
			spiOe_next = 1'b0;
			spiTx_next = ADDR_RESET;
			spiMiso_next = 1'b0;
		end else begin
			spiOe_next = 1'b1;
			spiLoad = spiPend_reg;
			if (spiPend_reg) begin
				spiTx_next = rdByte;
				spiTxAddr_next = addr_reg;
			end
			if (sclkFall) begin
				spiRx_next = spiRxByte;
				if (spiBit_reg == BITS_PER_BYTE - BIT_STEP) begin
					spiBit_next = BIT_RESET;
					spiFirst_next = 1'b0;
					if (spiFirst_reg) begin
						spiSetAddr = 1'b1;
						spiCmd = (spiRxByte == CMD_START_CONV);
						spiPend_next = (spiRxByte != CMD_START_CONV);
					end else begin
						spiWr = 1'b1;
						spiPend_next = 1'b1;
					end
				end else begin
					spiBit_next = spiBit_reg + BIT_STEP;
				end
			end
			if (sclkRise) begin
				spiMiso_next = spiTx_reg[7];
				spiTx_next = {spiTx_reg[6:0], 1'b0};
				spiRead = (spiBit_reg == BIT_RESET) && !spiFirst_reg;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			spiBit_reg <= BIT_RESET;
			spiRx_reg <= ADDR_RESET;
			spiTx_reg <= ADDR_RESET;
			spiTxAddr_reg <= ADDR_RESET;
			spiFirst_reg <= 1'b1;
			spiPend_reg <= 1'b0;
			spiMiso_reg <= 1'b0;
			spiOe_reg <= 1'b0;
		end else begin
			spiBit_reg <= spiBit_next;
			spiRx_reg <= spiRx_next;
			spiTx_reg <= spiTx_next;
			spiTxAddr_reg <= spiTxAddr_next;
			spiFirst_reg <= spiFirst_next;
			spiPend_reg <= spiPend_next;
			spiMiso_reg <= spiMiso_next;
			spiOe_reg <= spiOe_next;
		end
	end

	// ----------------------------------------------------------------
	// Shared address pointer, writes and conversion control
	// ----------------------------------------------------------------
	logic [7:0] addr_next, wrAddr_reg, wrAddr_next, wrData_reg, wrData_next;
	logic wrEn_reg, wrEn_next, conv_reg, conv_next, seen_reg, seen_next;
	logic start_reg, start_next, rdEv;
	logic [7:0] rdAddr;

	assign rdEv = i2cLoad || spiRead;
	assign rdAddr = spiRead ? spiTxAddr_reg : addr_reg;

	// SPI writes land on the byte just shifted out, one behind the pointer
	always_comb begin
		addr_next = addr_reg;
		wrAddr_next = wrAddr_reg;
		wrData_next = wrData_reg;
		wrEn_next = 1'b0;
		conv_next = conv_reg;
		seen_next = seen_reg;
		start_next = 1'b0;
		if (i2cSetAddr || spiSetAddr) begin
			addr_next = spiSetAddr ? spiRxByte : shift_reg;
		end
		if (i2cCmd || spiCmd) begin
			conv_next = 1'b1;
		end
		if (i2cWr || spiWr) begin
			wrEn_next = 1'b1;
			wrAddr_next = spiWr ? addr_reg - ADDR_STEP : addr_reg;
			wrData_next = spiWr ? spiRxByte : shift_reg;
			if (i2cWr) begin
				addr_next = addr_reg + ADDR_STEP;
			end
		end
		if (i2cLoad || spiLoad) begin
			addr_next = addr_reg + ADDR_STEP;
		end
		if (rdEv) begin
			if (isData(rdAddr)) begin
				seen_next = 1'b1;
			end else begin
				conv_next = 1'b0;
			end
		end
		if (i2cEnd || spiEnd) begin
			start_next = seen_reg && conv_reg;
			seen_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			addr_reg <= ADDR_RESET;
			wrAddr_reg <= ADDR_RESET;
			wrData_reg <= ADDR_RESET;
			wrEn_reg <= 1'b0;
			conv_reg <= 1'b0;
			seen_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			addr_reg <= addr_next;
			wrAddr_reg <= wrAddr_next;
			wrData_reg <= wrData_next;
			wrEn_reg <= wrEn_next;
			conv_reg <= conv_next;
			seen_reg <= seen_next;
			start_reg <= start_next;
		end
	end

	// Open-drain lines only ever pull low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = sclHold_reg;
	assign sdaOe = sdaLow_reg;
	assign spiMiso = spiMiso_reg;
	assign spiMisoOe = spiOe_reg;
	assign regRdAddr = addr_reg;
	assign regWrEn = wrEn_reg;
	assign regWrAddr = wrAddr_reg;
	assign regWrData = wrData_reg;
	assign convRunning = conv_reg;
	assign convStart = start_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_addr_ack;
		i2cOn && !evAny && i2cState_reg == I2C_ADDR && sclFall && bitCnt_reg == BITS_PER_BYTE
			&& shift_reg[7:1] == I2C_TARGET_ADDR |=> sdaOe && i2cState_reg == I2C_ACK_OUT;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");
	property p_addr_ignore;
		i2cOn && !evAny && i2cState_reg == I2C_ADDR && sclFall && bitCnt_reg == BITS_PER_BYTE
			&& shift_reg[7:1] != I2C_TARGET_ADDR |=> !sdaOe && i2cState_reg == I2C_IDLE;
	endproperty
	a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address answered");
	property p_wr_ack;
		i2cWr |=> sdaOe ##1 (sdaOe || i2cState_reg != I2C_ACK_OUT);
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");
	property p_sda_stable;
		sclS && pinPrev_reg[PIN_SCL] && $past(i2cOn) && !$past(evAny) |-> $stable(sdaOe);
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("SDA moved while SCL high");
	property p_stretch;
		i2cOn && !evAny && i2cState_reg == I2C_LOAD && !dataReady |=> sclOe;
	endproperty
	a_stretch: assert property (p_stretch) else $error("SCL not held while data not ready");
	property p_release;
		i2cOn && !evAny && i2cState_reg == I2C_LOAD && dataReady |=> i2cState_reg == I2C_READ
			##1 !sclOe;
	endproperty
	a_release: assert property (p_release) else $error("SCL not released when ready");
	property p_autoinc;
		i2cLoad |=> regRdAddr == $past(regRdAddr) + ADDR_STEP;
	endproperty
	a_autoinc: assert property (p_autoinc) else $error("read pointer did not advance");
	property p_i2c_off;
		!i2cOn |=> i2cState_reg == I2C_IDLE && !sdaOe && !sclOe;
	endproperty
	a_i2c_off: assert property (p_i2c_off) else $error("I2C active while deselected");
	property p_spi_off;
		i2cOn |=> !spiMisoOe;
	endproperty
	a_spi_off: assert property (p_spi_off) else $error("MISO driven in I2C mode");
	property p_spi_shift;
		spiOn && !csS && sclkRise |=> spiMiso == $past(spiTx_reg[7]);
	endproperty
	a_spi_shift: assert property (p_spi_shift) else $error("MISO not MSB on rising edge");
	property p_conv_stop;
		rdEv && !isData(rdAddr) |=> !convRunning;
	endproperty
	a_conv_stop: assert property (p_conv_stop) else $error("conversions not stopped");
	property p_conv_trig;
		(i2cEnd || spiEnd) && seen_reg && conv_reg |=> convStart ##1 !convStart;
	endproperty
	a_conv_trig: assert property (p_conv_trig) else $error("no single conversion trigger");

endmodule : ssh_serial_host_if

`default_nettype wire

/* File: verif/ssh_host_model.sv */
// Host master model driving the I2C and SPI pins of the sensor interface
`timescale 1ns/1ps
`default_nettype none

module ssh_host_model #(
	parameter int QTR = 500
) (
	input wire logic clock,
	input wire logic sclOe,
	input wire logic sdaOe,
	input wire logic spiMiso,
	input wire logic spiMisoOe,
	output logic sclIn,
	output logic sdaIn,
	output logic spiSclk,
	output logic spiCsN,
	output logic spiMosi
);
	logic sclDrv = 1'b1;
	logic sdaDrv = 1'b1;
	int toCnt = 0;

	// Pull-ups: whoever pulls low wins
	assign sclIn = sclDrv & ~sclOe;
	assign sdaIn = sdaDrv & ~sdaOe;

	// SPI clock stands still low outside frames
	initial begin
		spiSclk = 1'b0;
		spiCsN = 1'b1;
		spiMosi = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	// ------------------------------------------------
	// I2C master, QTR cycles per quarter bit
	// ------------------------------------------------
	// One SCL pulse; a stretched clock is waited out, but not forever
	task automatic bitx(input logic b, output logic r);
		int k;
		sdaDrv <= b;
		tick(QTR);
		sclDrv <= 1'b1;
		tick(1);
		k = 0;
		while (sclIn !== 1'b1 && k < 20000) begin
			tick(1);
			k++;
		end
		if (k == 20000) toCnt++;
		tick(QTR);
		r = sdaIn;
		tick(QTR);
		sclDrv <= 1'b0;
		tick(QTR);
	endtask : bitx

	// Start or repeated start, SDA falling while SCL high
	task automatic start();
		sdaDrv <= 1'b1;
		tick(QTR);
		sclDrv <= 1'b1;
		tick(QTR);
		sdaDrv <= 1'b0;
		tick(QTR);
		sclDrv <= 1'b0;
		tick(QTR);
	endtask : start

	task automatic stop();
		sdaDrv <= 1'b0;
		tick(QTR);
		sclDrv <= 1'b1;
		tick(QTR);
		sdaDrv <= 1'b1;
		tick(QTR);
	endtask : stop

	// Eight bits MSB first, then the ninth bit; ackIn high releases SDA
	task automatic byteX(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx,
		output logic ackSeen);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(tx[i], r);
			rx[i] = r;
		end
		bitx(ackIn, r);
		ackSeen = ~r;
	endtask : byteX

	// ------------------------------------------------
	// SPI mode 1 master, 65 ns per clock
	// ------------------------------------------------
	// MOSI moves on the rise; MISO is taken just before the fall
	task automatic spiByte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			spiSclk <= 1'b1;
			spiMosi <= tx[i];
			tick(7);
			rx[i] = spiMisoOe ? spiMiso : ~spiMiso; // Undriven line reads as the wrong bit
			spiSclk <= 1'b0;
			tick(6);
		end
	endtask : spiByte

	// Chip select edge; MOSI flips so no stale level is left behind
	task automatic spiFrame(input logic cs);
		spiCsN <= cs;
		spiMosi <= ~spiMosi;
		tick(cs ? ssh_pkg::CS_GAP_CYC : 30);
	endtask : spiFrame
endmodule : ssh_host_model

`default_nettype wire

/* File: verif/ssh_serial_host_if_tb.sv */
// Self-checking bench for the sensor serial host interface
`timescale 1ns/1ps
`default_nettype none

module ssh_serial_host_if_tb;
	import ssh_pkg::*;

	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic interfaceSelectPin = 1'b1;
	logic [31:0] pressureData = 32'h44332211;
	logic [31:0] temperatureData = 32'h88776655;
	logic dataReady = 1'b1;
	logic [7:0] regRdData = 8'h5A;
	wire logic sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe, spiSclk, spiCsN, spiMosi;
	wire logic spiMiso, spiMisoOe, regWrEn, convRunning, convStart;
	wire logic [7:0] regRdAddr, regWrAddr, regWrData;
	int error_cnt = 0;
	int check_count = 0;
	int startCount = 0;
	logic [7:0] wrA, wrD, rx;
	logic ack;
	logic stretchSeen = 1'b0;
	logic oeSeen = 1'b0;

	always #2.5 clock = ~clock;

	ssh_serial_host_if ssh_serial_host_if_i (.clock, .rst_n, .interfaceSelectPin, .sclIn,
		.sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe, .spiSclk, .spiCsN, .spiMosi, .spiMiso,
		.spiMisoOe, .pressureData, .temperatureData, .dataReady, .regRdData, .regRdAddr,
		.regWrEn, .regWrAddr, .regWrData, .convRunning, .convStart);

	// Quarter bit shortened so the I2C traffic fits the run
	ssh_host_model #(.QTR(16)) ssh_host_model_i (.clock, .sclOe, .sdaOe, .spiMiso, .sclIn,
		.sdaIn, .spiSclk, .spiCsN, .spiMosi, .spiMisoOe);

	// Capture write strobes, conversion requests and any SCL or SDA drive
	always @(posedge clock) begin
		if (regWrEn === 1'b1) begin
			wrA = regWrAddr;
			wrD = regWrData;
		end
		if (convStart === 1'b1) startCount++;
		if (sclOe === 1'b1) stretchSeen = 1'b1;
		if (sdaOe === 1'b1) oeSeen = 1'b1;
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic results();
		error_cnt += ssh_host_model_i.toCnt;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// Start plus address byte, which the target must acknowledge
	task automatic i2cAddr(input logic rw);
		ssh_host_model_i.start();
		ssh_host_model_i.byteX({I2C_TARGET_ADDR, rw}, 1'b1, rx, ack);
		chk("addr ack", 8'h01, {7'h00, ack});
	endtask : i2cAddr

	task automatic i2cPut(input logic [7:0] b);
		ssh_host_model_i.byteX(b, 1'b1, rx, ack);
		chk("write ack", 8'h01, {7'h00, ack});
	endtask : i2cPut

	task automatic i2cGet(input logic [7:0] e, input logic last);
		ssh_host_model_i.byteX(8'hFF, last, rx, ack);
		chk("read byte", e, rx);
	endtask : i2cGet

	// Hang guard
	initial begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		results();
	end

	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		chk("idle", 8'h00, {sclOe, sdaOe, spiMisoOe, convRunning, regRdAddr[3:0]});
		chk("od levels", 8'h00, {6'h00, sclOut, sdaOut});
		i2cAddr(1'b0);
		i2cPut(CMD_START_CONV);
		ssh_host_model_i.stop();
		chk("running", 8'h01, {7'h00, convRunning});
		// Pressure into temperature in one read, first byte held back
		dataReady <= 1'b0;
		pressureData <= 32'hD4C3B2A1;
		fork
			begin
				for (int k = 0; k < 9000 && sclOe !== 1'b1; k++) @(posedge clock);
				if (sclOe !== 1'b1) error_cnt++;
				repeat (40) @(posedge clock);
				dataReady <= 1'b1;
			end
		join_none
		i2cAddr(1'b0);
		i2cPut(PRESS_BASE);
		i2cAddr(1'b1);
		for (int i = 0; i < 5; i++) begin
			i2cGet(8'({temperatureData, pressureData} >> (8 * i)), i == 4);
		end
		ssh_host_model_i.stop();
		repeat (20) @(posedge clock);
		chk("stretch", 8'h01, {7'h00, stretchSeen});
		chk("conv starts", 8'h01, 8'(startCount));
		// Other reads stop conversions; then a plain register write
		regRdData <= 8'hC7;
		i2cAddr(1'b0);
		i2cPut(8'h10);
		i2cAddr(1'b1);
		i2cGet(regRdData, 1'b1);
		ssh_host_model_i.stop();
		chk("stopped", 8'h00, {7'h00, convRunning});
		chk("rd ptr", 8'h11, regRdAddr);
		i2cAddr(1'b0);
		i2cPut(8'h10);
		i2cPut(8'hA5);
		ssh_host_model_i.stop();
		chk("wr addr", 8'h10, wrA);
		chk("wr data", 8'hA5, wrD);
		// Foreign address, then own address with I2C deselected
		ssh_host_model_i.start();
		ssh_host_model_i.byteX({7'h29, 1'b0}, 1'b1, rx, ack);
		ssh_host_model_i.stop();
		chk("foreign ack", 8'h00, {7'h00, ack});
		interfaceSelectPin <= 1'b0;
		repeat (10) @(posedge clock);
		oeSeen = 1'b0;
		ssh_host_model_i.start();
		ssh_host_model_i.byteX({I2C_TARGET_ADDR, 1'b0}, 1'b1, rx, ack);
		ssh_host_model_i.stop();
		chk("deselected", 8'h00, {6'h00, ack, oeSeen});
		// SPI: command, two-byte temperature read, register write
		ssh_host_model_i.spiFrame(1'b0);
		ssh_host_model_i.spiByte(CMD_START_CONV, rx);
		ssh_host_model_i.spiFrame(1'b1);
		chk("spi running", 8'h01, {7'h00, convRunning});
		temperatureData <= 32'h0F1E2D3C;
		ssh_host_model_i.spiFrame(1'b0);
		ssh_host_model_i.spiByte(TEMP_BASE, rx);
		ssh_host_model_i.spiByte(8'h00, rx);
		chk("spi byte0", temperatureData[7:0], rx);
		ssh_host_model_i.spiByte(8'h00, rx);
		chk("spi byte1", temperatureData[15:8], rx);
		chk("miso oe", 8'h01, {7'h00, spiMisoOe});
		ssh_host_model_i.spiFrame(1'b1);
		chk("spi conv", 8'h02, 8'(startCount));
		ssh_host_model_i.spiFrame(1'b0);
		ssh_host_model_i.spiByte(8'h20, rx);
		ssh_host_model_i.spiByte(8'h3C, rx);
		ssh_host_model_i.spiFrame(1'b1);
		chk("spi wr addr", 8'h20, wrA);
		chk("spi wr data", 8'h3C, wrD);
		chk("spi stop", 8'h00, {7'h00, convRunning});
		results();
	end
endmodule : ssh_serial_host_if_tb

`default_nettype wire
